// file: iqf_formatter.sv
// Purpose: serial I/Q output formatter with bit clock, word strobe and time slots
// Assumes: samples arrive on i_clock with a one-cycle valid; pins are resolved outside
// Notes: a control word is latched in two writes; the high write issues it
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "iqf_regs.svh"
module iqf_formatter (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire iqf_pkg::iqf_sample_t i_sample,
	input wire logic i_sample_valid,
	output iqf_pkg::iqf_pins_t o_pins
);
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] cw_low;
	logic do_write;
	logic cmd_valid;
	logic [39:0] cmd_word;
	iqf_pkg::iqf_shape_t shape;
	iqf_pkg::iqf_format_t fmt;
	iqf_pkg::iqf_tx_t state;
	logic [12:0] rate_cnt;
	logic [12:0] eff_preload;
	logic tick;
	logic [5:0] bit_idx;
	logic [5:0] slot_cnt;
	logic [5:0] nbits;
	logic word_idx;
	logic last_bit;
	logic last_word;
	logic slot_end;
	logic own_slot;
	logic next_own;
	logic start_next;
	logic sending;
	iqf_pkg::iqf_sample_t hold;
	iqf_pkg::iqf_sample_t shift;
	logic pending;
	logic i_bit;
	logic q_bit;
	logic clk_act;
	logic stb_act;
	iqf_pkg::iqf_pins_t next_pins;

	function automatic logic [5:0] word_bits(input logic [1:0] code);
		case (code)
			2'h0: word_bits = `IQF_BITS_16;
			2'h1: word_bits = `IQF_BITS_24;
			2'h2: word_bits = `IQF_BITS_32;
			default: word_bits = `IQF_BITS_38;
		endcase
	endfunction : word_bits

	function automatic logic pick(input logic [37:0] w, input logic [5:0] n,
		input logic [5:0] idx, input logic msb);
		logic [5:0] pos;
		pos = msb ? 6'(n - idx - 6'h01) : idx;
		pick = w[pos];
	endfunction : pick

	function automatic logic drive(input logic [1:0] mode, input logic own);
		drive = mode[1] ? own : mode[0];
	endfunction : drive

	// write channel: address and data taken in either order, answered once both held
	assign do_write = !o_awready && !o_wready && !o_bvalid;

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			o_awready <= 1'b1;
			aw_addr <= 8'h00;
		end
		else if (i_awvalid && o_awready)
		begin
			o_awready <= 1'b0;
			aw_addr <= i_awaddr;
		end
		else if (o_bvalid && i_bready)
			o_awready <= 1'b1;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			o_wready <= 1'b1;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else if (i_wvalid && o_wready)
		begin
			o_wready <= 1'b0;
			w_data <= i_wdata;
			w_strb <= i_wstrb;
		end
		else if (o_bvalid && i_bready)
			o_wready <= 1'b1;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			o_bvalid <= 1'b0;
			o_bresp <= `IQF_RESP_OKAY;
		end
		else if (do_write)
		begin
			o_bvalid <= 1'b1;
			o_bresp <= (aw_addr == `IQF_OFS_CW_LOW || aw_addr == `IQF_OFS_CW_HIGH) ?
				`IQF_RESP_OKAY : `IQF_RESP_SLVERR;
		end
		else if (i_bready)
			o_bvalid <= 1'b0;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			cw_low <= 32'h00000000;
		else if (do_write && aw_addr == `IQF_OFS_CW_LOW)
		begin
			for (int b = 0; b < 4; b++)
				if (w_strb[b])
					cw_low[b*8 +: 8] <= w_data[b*8 +: 8];
		end
	end

	// the high byte write issues the whole 40-bit word as a one-cycle command
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			cmd_valid <= 1'b0;
			cmd_word <= 40'h0000000000;
		end
		else
		begin
			cmd_valid <= do_write && aw_addr == `IQF_OFS_CW_HIGH && w_strb[0];
			cmd_word <= {w_data[7:0], cw_low};
		end
	end

	// word decode and update
	// with only two words held here, update-all re-applies the other word unchanged
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			shape <= `IQF_RST_SHAPE;
			fmt <= `IQF_RST_FORMAT;
		end
		else if (cmd_valid)
		begin
			if (cmd_word[`IQF_F_ADDR_HI:`IQF_F_ADDR_LO] == `IQF_IDX_SHAPE)
				shape <= cmd_word[`IQF_F_SHAPE_HI:0];
			if (cmd_word[`IQF_F_ADDR_HI:`IQF_F_ADDR_LO] == `IQF_IDX_FORMAT)
				fmt <= {cmd_word[`IQF_F_FMT_HI:`IQF_F_FMT_LO], cmd_word[`IQF_F_PRE_HI:0]};
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= `IQF_RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= `IQF_RESP_OKAY;
			case (i_araddr)
				`IQF_OFS_CW_LOW: o_rdata <= cw_low;
				`IQF_OFS_CW_HIGH: o_rdata <= 32'h00000000;
				`IQF_OFS_STATUS: o_rdata <= {18'h00000, sending, pending, slot_cnt, bit_idx};
				`IQF_OFS_SHAPE: o_rdata <= {29'h00000000, shape};
				`IQF_OFS_FORMAT: o_rdata <= fmt[31:0];
				default:
				begin
					o_rdata <= 32'h00000000;
					o_rresp <= `IQF_RESP_SLVERR;
				end
			endcase
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// preload clamp
	// out-of-range preloads are clamped so the bit period never drops below three clocks
	assign eff_preload = (fmt.preload < `IQF_PRELOAD_MIN) ? `IQF_PRELOAD_MIN :
		(fmt.preload > `IQF_PRELOAD_MAX) ? `IQF_PRELOAD_MAX : fmt.preload;
	assign tick = rate_cnt == 13'h0000;

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			rate_cnt <= 13'h0000;
		else if (tick)
			rate_cnt <= eff_preload;
		else
			rate_cnt <= rate_cnt - 13'h0001;
	end

	assign nbits = word_bits(shape.width_code);
	assign last_bit = bit_idx >= 6'(nbits - 6'h01);
	assign last_word = !fmt.iq_merge || word_idx;
	assign slot_end = tick && last_bit && last_word;
	assign own_slot = slot_cnt == fmt.slot;
	assign next_own = 6'(slot_cnt + 6'h01) == fmt.slot;
	assign start_next = slot_end && next_own && pending;
	assign sending = state == iqf_pkg::IQF_TX_SEND;

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			bit_idx <= 6'h00;
			word_idx <= 1'b0;
			slot_cnt <= 6'h00;
		end
		else if (tick)
		begin
			if (last_bit)
			begin
				bit_idx <= 6'h00;
				word_idx <= !last_word;
				if (last_word)
					slot_cnt <= 6'(slot_cnt + 6'h01);
			end
			else
				bit_idx <= 6'(bit_idx + 6'h01);
		end
	end

	// a new sample wins over the clear from a slot start in the same cycle
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			pending <= 1'b0;
		else if (i_sample_valid)
			pending <= 1'b1;
		else if (start_next)
			pending <= 1'b0;
	end

	// an unsent sample is overwritten: only the newest result goes out
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			hold <= '0;
		else if (i_sample_valid)
			hold <= i_sample;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			state <= iqf_pkg::IQF_TX_WAIT;
			shift <= '0;
		end
		else if (slot_end)
		begin
			case (state)
				iqf_pkg::IQF_TX_WAIT,
				iqf_pkg::IQF_TX_SEND:
					state <= start_next ? iqf_pkg::IQF_TX_SEND : iqf_pkg::IQF_TX_WAIT;
				default: state <= iqf_pkg::IQF_TX_WAIT;
			endcase
			if (start_next)
				shift <= hold;
		end
	end

	assign i_bit = word_idx ? (pick(shift.q, nbits, bit_idx, shape.msb_first) ^ fmt.q_inv) :
		(pick(shift.i, nbits, bit_idx, shape.msb_first) ^ fmt.i_inv);
	assign q_bit = pick(shift.q, nbits, bit_idx, shape.msb_first) ^ fmt.q_inv;

	assign clk_act = fmt.clk_duty ? (rate_cnt > (eff_preload >> 1)) : (rate_cnt == eff_preload);

	assign stb_act = fmt.stb_during ? (sending && bit_idx == 6'h00) :
		((sending && fmt.iq_merge && !word_idx && last_bit) ||
		(last_bit && last_word && next_own && pending));

	always_comb
	begin
		next_pins = '0;
		next_pins.clk = ((fmt.clk_cont || sending) && clk_act) ^ !fmt.clk_pol;
		next_pins.clk_oe = drive(fmt.clk_tri, own_slot);
		next_pins.stb = stb_act ^ fmt.stb_pol;
		next_pins.stb_oe = drive(fmt.stb_tri, own_slot);
		next_pins.i_data = sending && i_bit;
		next_pins.i_oe = drive(fmt.i_tri, own_slot);
		next_pins.q_data = sending && !fmt.iq_merge && q_bit;
		next_pins.q_oe = drive(fmt.q_tri, own_slot);
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			o_pins <= '0;
		else
			o_pins <= next_pins;
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	sequence s_fmt_cmd;
		cmd_valid && cmd_word[39:37] == 3'h6;
	endsequence
	sequence s_shape_cmd_single;
		cmd_valid && cmd_word[39:37] == 3'h5 && !cmd_word[36];
	endsequence
	sequence s_reload;
		tick ##1 (rate_cnt == eff_preload);
	endsequence

	a_width_decode: assert property (shape.width_code == 2'h3 |-> nbits == 6'h26)
		else $error("38-bit width code not decoded");
	a_word_select: assert property (s_fmt_cmd |=> fmt.preload == $past(cmd_word[12:0]))
		else $error("format word not applied");
	a_update_single: assert property (s_shape_cmd_single |=> $stable(fmt))
		else $error("single update changed another word");
	a_merge_quiet: assert property (fmt.iq_merge && $stable(fmt) |=> !o_pins.q_data)
		else $error("q pin active in merged mode");
	a_slot_advance: assert property (slot_end |=> slot_cnt == $past(slot_cnt) + 6'h01)
		else $error("slot counter did not advance");
	a_clock_idle: assert property (!sending && !fmt.clk_cont && $stable(fmt)
		|=> o_pins.clk == !$past(fmt.clk_pol))
		else $error("gated bit clock not at idle level");
	a_pulse_short: assert property (!fmt.clk_duty && fmt.clk_cont && $stable(fmt) [*3]
		|-> !(clk_act && $past(clk_act)))
		else $error("short clock pulse lasted two cycles");
	a_gated_clock: assert property (!fmt.clk_cont && !sending ##1 $stable(fmt)
		|-> o_pins.clk == !fmt.clk_pol)
		else $error("gated clock toggled outside a word");
	a_clock_off: assert property (fmt.clk_tri == 2'h0 && $stable(fmt) |=> !o_pins.clk_oe)
		else $error("clock driven while set off");
	a_strobe_drive: assert property (fmt.stb_tri == 2'h1 && $stable(fmt) |=> o_pins.stb_oe)
		else $error("strobe not driven");
	a_strobe_level: assert property (!stb_act && $stable(fmt)
		|=> o_pins.stb == $past(fmt.stb_pol))
		else $error("strobe inactive level wrong");
	a_i_drive: assert property (fmt.i_tri[1] && $stable(fmt) |=> o_pins.i_oe == $past(own_slot))
		else $error("i pin drive not tied to own slot");
	a_q_drive: assert property (fmt.q_tri == 2'h1 && $stable(fmt) |=> o_pins.q_oe)
		else $error("q pin not driven");
	a_rate_reload: assert property (s_reload |-> ##1 (rate_cnt == eff_preload - 13'h0001
		|| $changed(fmt)))
		else $error("bit rate counter did not reload and count");
	a_slot_release: assert property (fmt.clk_tri[1] && !own_slot && $stable(fmt)
		|=> !o_pins.clk_oe)
		else $error("clock driven outside own slot");
endmodule : iqf_formatter
`default_nettype wire

// file: iqf_regs.svh
// Purpose: register offsets, control word fields, reset values and counts for iqf_formatter
// Assumes: 32-bit AXI4-Lite register port, 40-bit control words built from two bus writes
// Notes: definitions only
`ifndef IQF_REGS_SVH
`define IQF_REGS_SVH
`define IQF_OFS_CW_LOW 8'h00
`define IQF_OFS_CW_HIGH 8'h04
`define IQF_OFS_STATUS 8'h08
`define IQF_OFS_SHAPE 8'h14
`define IQF_OFS_FORMAT 8'h18
`define IQF_IDX_SHAPE 3'h5
`define IQF_IDX_FORMAT 3'h6
`define IQF_F_ADDR_HI 39
`define IQF_F_ADDR_LO 37
`define IQF_F_UPDATE 36
`define IQF_F_FMT_HI 35
`define IQF_F_FMT_LO 14
`define IQF_F_PRE_HI 12
`define IQF_F_SHAPE_HI 2
`define IQF_BITS_16 6'h10
`define IQF_BITS_24 6'h18
`define IQF_BITS_32 6'h20
`define IQF_BITS_38 6'h26
`define IQF_RST_SHAPE 3'h0
`define IQF_RST_FORMAT 35'h0
`define IQF_PRELOAD_MIN 13'h0002
`define IQF_PRELOAD_MAX 13'h06A5
`define IQF_RESP_OKAY 2'h0
`define IQF_RESP_SLVERR 2'h2
`endif

// file: iqf_pkg.sv
// Purpose: types shared by the serial output formatter
// Assumes: field order of iqf_format_t follows control word bits 35-14 then 12-0
// Notes: no constants here, see iqf_regs.svh
`default_nettype none
package iqf_pkg;
	typedef struct packed {
		logic [1:0] width_code;
		logic msb_first;
	} iqf_shape_t;
	typedef struct packed {
		logic iq_merge;
		logic [5:0] slot;
		logic clk_pol;
		logic clk_duty;
		logic clk_cont;
		logic [1:0] clk_tri;
		logic stb_pol;
		logic stb_during;
		logic [1:0] stb_tri;
		logic i_inv;
		logic [1:0] i_tri;
		logic q_inv;
		logic [1:0] q_tri;
		logic [12:0] preload;
	} iqf_format_t;
	typedef struct packed {
		logic [37:0] i;
		logic [37:0] q;
	} iqf_sample_t;
	typedef struct packed {
		logic clk;
		logic clk_oe;
		logic stb;
		logic stb_oe;
		logic i_data;
		logic i_oe;
		logic q_data;
		logic q_oe;
	} iqf_pins_t;
	typedef enum logic [1:0] {
		IQF_TX_WAIT = 2'b01,
		IQF_TX_SEND = 2'b10
	} iqf_tx_t;
endpackage : iqf_pkg
`default_nettype wire

// file: iqf_rx_model.sv
// Purpose: downstream serial receiver for iqf_formatter
// Assumes: pins sampled on i_clock; gated bit clock while words are checked
// Notes: a released clock, I or Q pin reads as the inverse of its last level; a released strobe is not counted
`timescale 1ns/100ps
`default_nettype none
module iqf_rx_model (
	input wire logic i_clock,
	input wire iqf_pkg::iqf_pins_t i_pins,
	input wire logic i_clk_pol,
	input wire logic i_stb_pol,
	input wire logic i_clear,
	output logic [75:0] o_i_bits,
	output logic [75:0] o_q_bits,
	output logic [7:0] o_bits,
	output logic [7:0] o_clk_act,
	output logic [7:0] o_stb_act
);
	logic clk_last, i_last, q_last;
	logic clk_w, i_w, q_w;
	// floating lines must not look like a held value
	assign clk_w = i_pins.clk_oe ? i_pins.clk : ~clk_last;
	assign i_w = i_pins.i_oe ? i_pins.i_data : ~i_last;
	assign q_w = i_pins.q_oe ? i_pins.q_data : ~q_last;
	always @(posedge i_clock)
	begin
		// clear to the idle level so the first sample after a clear is no false edge
		clk_last <= i_clear ? ~i_clk_pol : clk_w;
		i_last <= i_clear ? 1'b0 : i_w;
		q_last <= i_clear ? 1'b0 : q_w;
		if (i_clear)
		begin
			o_bits <= 8'h00;
			o_clk_act <= 8'h00;
			o_stb_act <= 8'h00;
		end
		else
		begin
			// take data at the stable edge
			if (clk_w == ~i_clk_pol && clk_last == i_clk_pol)
			begin
				o_i_bits <= {o_i_bits[74:0], i_w};
				o_q_bits <= {o_q_bits[74:0], q_w};
				o_bits <= o_bits + 8'h01;
			end
			if (i_pins.clk_oe && clk_w == i_clk_pol)
				o_clk_act <= o_clk_act + 8'h01;
			if (i_pins.stb_oe && i_pins.stb != i_stb_pol)
				o_stb_act <= o_stb_act + 8'h01;
		end
	end
endmodule : iqf_rx_model
`default_nettype wire

// file: iqf_formatter_tb.sv
// Purpose: self-checking bench for iqf_formatter
// Assumes: AXI4-Lite master tasks, receiver model on the pins
// Notes: preload 2 or 3 keeps slot cycles short
`timescale 1ns/100ps
`default_nettype none
`include "iqf_regs.svh"
module iqf_formatter_tb;
	logic i_clock, i_resetn, awvalid, wvalid, bready, arvalid, rready, svalid, clr, cpol, spol;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, rx_n, rx_clk, rx_stb;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [75:0] rx_i, rx_q;
	iqf_pkg::iqf_sample_t smp;
	iqf_pkg::iqf_pins_t pins;
	iqf_pkg::iqf_format_t f;
	int miscompares, compares;
	iqf_formatter u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
		.i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_sample(smp), .i_sample_valid(svalid), .o_pins(pins));
	iqf_rx_model u_rx (.i_clock(i_clock), .i_pins(pins), .i_clk_pol(cpol), .i_stb_pol(spol),
		.i_clear(clr), .o_i_bits(rx_i), .o_q_bits(rx_q), .o_bits(rx_n), .o_clk_act(rx_clk),
		.o_stb_act(rx_stb));
	initial
	begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("Error at %0t ns: %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge i_clock);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 100)
		begin
			@(posedge i_clock);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				bready <= 1'b0;
				rs = bresp;
				n = 1000;
			end
		end
		chk(n == 1000, "write not answered");
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge i_clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 100)
		begin
			@(posedge i_clock);
			n++;
			if (arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rready <= 1'b0;
				v = rdata;
				rs = rresp;
				n = 1000;
			end
		end
		chk(n == 1000, "read not answered");
	endtask : rd
	task automatic cw(input logic [39:0] w);
		wr(`IQF_OFS_CW_LOW, w[31:0], r);
		chk(r === `IQF_RESP_OKAY, "low word refused");
		wr(`IQF_OFS_CW_HIGH, {24'h000000, w[39:32]}, r);
		chk(r === `IQF_RESP_OKAY, "high word refused");
	endtask : cw
	function automatic logic [39:0] fcw(input iqf_pkg::iqf_format_t g, input logic u);
		return {3'b110, u, g[34:13], 1'b0, g[12:0]};
	endfunction : fcw
	function automatic logic [37:0] rev(input logic [37:0] v, input int n);
		logic [37:0] o;
		o = '0;
		for (int k = 0; k < n; k++) o[k] = v[n-1-k];
		return o;
	endfunction : rev
	task automatic send(input logic [7:0] n);
		int t;
		t = 0;
		@(posedge i_clock);
		clr <= 1'b1;
		svalid <= 1'b1;
		@(posedge i_clock);
		clr <= 1'b0;
		svalid <= 1'b0;
		while (rx_n !== n && t < 20000)
		begin
			@(posedge i_clock);
			t++;
		end
		repeat (20) @(posedge i_clock);
		chk(rx_n === n, "bit count wrong");
	endtask : send
	task automatic t_reset;
		chk({pins.clk_oe, pins.stb_oe, pins.i_oe, pins.q_oe} === 4'h0, "pins driven");
		rd(`IQF_OFS_FORMAT, d, r);
		chk(d === 32'h00000000, "format not reset");
		rd(8'h0C, d, r);
		chk(r === `IQF_RESP_SLVERR, "unmapped read ok");
		wr(`IQF_OFS_STATUS, 32'h0000FFFF, r);
		chk(r === `IQF_RESP_SLVERR, "status write ok");
	endtask : t_reset
	task automatic t_basic;
		cw({3'b101, 34'h0, 3'b000});
		f = '{1'b0, 6'h00, 1'b0, 1'b0, 1'b0, 2'b01, 1'b0, 1'b1, 2'b01, 1'b0, 2'b01, 1'b0, 2'b01,
			13'h0002};
		cw(fcw(f, 1'b0));
		rd(`IQF_OFS_FORMAT, d, r);
		chk(d === f[31:0], "format readback");
		send(8'h10);
		chk(rx_i[15:0] === rev(smp.i, 16), "lsb first I");
		chk(rx_q[15:0] === rev(smp.q, 16), "lsb first Q");
		chk(rx_clk === 8'h10, "clock active time");
		chk(rx_stb === 8'h03, "strobe length");
		cw({3'b111, 37'h0000000000});
		rd(`IQF_OFS_FORMAT, d, r);
		chk(d === f[31:0], "foreign code applied");
	endtask : t_basic
	task automatic t_msb;
		cpol <= 1'b1;
		cw({3'b101, 34'h0, 3'b011});
		rd(`IQF_OFS_SHAPE, d, r);
		chk(d === 32'h00000003, "shape readback");
		f = '{1'b0, 6'h00, 1'b1, 1'b1, 1'b0, 2'b01, 1'b0, 1'b1, 2'b01, 1'b1, 2'b01, 1'b0, 2'b01,
			13'h0003};
		cw(fcw(f, 1'b0));
		send(8'h18);
		chk(rx_i[23:0] === ~smp.i[23:0], "msb first inverted I");
		chk(rx_q[23:0] === smp.q[23:0], "msb first Q");
		chk(rx_clk === 8'h30, "half duty clock");
	endtask : t_msb
	task automatic t_merge;
		cpol <= 1'b0;
		spol <= 1'b1;
		cw({3'b101, 34'h0, 3'b001});
		f = '{1'b1, 6'h00, 1'b0, 1'b0, 1'b0, 2'b01, 1'b1, 1'b0, 2'b01, 1'b0, 2'b01, 1'b1, 2'b01,
			13'h0002};
		cw(fcw(f, 1'b1));
		send(8'h20);
		chk(rx_i[31:0] === {smp.i[15:0], ~smp.q[15:0]}, "I then Q");
		chk(rx_q[31:0] === 32'h00000000, "Q pin not idle");
		chk(rx_stb === 8'h06, "strobe before each word");
	endtask : t_merge
	task automatic t_slot;
		int c, s, i, q;
		c = 0;
		s = 0;
		i = 0;
		q = 0;
		cw({3'b101, 34'h0, 3'b000});
		f = '{1'b0, 6'h01, 1'b0, 1'b0, 1'b1, 2'b11, 1'b0, 1'b1, 2'b10, 1'b0, 2'b00, 1'b0, 2'b01,
			13'h0002};
		cw(fcw(f, 1'b0));
		// let the slot cut short by the mode change finish first
		repeat (100) @(posedge i_clock);
		repeat (3072)
		begin
			@(posedge i_clock);
			c += pins.clk_oe;
			s += pins.stb_oe;
			i += pins.i_oe;
			q += pins.q_oe;
		end
		chk(c == 48, "clock own slot");
		chk(s == 48, "strobe own slot");
		chk(i == 0, "I pin off");
		chk(q == 3072, "Q pin on");
	endtask : t_slot
	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	initial
	begin
		#4000000;
		miscompares++;
		stop_test();
	end
	initial
	begin
		miscompares = 0;
		compares = 0;
		{i_resetn, awvalid, wvalid, bready, arvalid, rready, svalid, cpol, spol} = '0;
		{awaddr, araddr, wdata} = '0;
		clr = 1'b1;
		smp = {38'h2A_5A5A_A5C3, 38'h15_1234_3C96};
		repeat (20) @(posedge i_clock);
		i_resetn <= 1'b1;
		t_reset();
		t_basic();
		t_msb();
		t_merge();
		t_slot();
		stop_test();
	end
endmodule : iqf_formatter_tb
`default_nettype wire
